// ===== hw/erpb_regs.svh
// What this block does
// RULE1 - the spectrometer error report carries version 000, type 0, header flag 1, application 1000111, category 111 and segmentation 11.
// RULE2 - each application and category pair has its own 14-bit sequence counter that starts at zero and steps by one per packet sent.
// RULE3 - the length field is the source data byte count plus nine, so 0000000000001011 for the spectrometer report.
// RULE4 - a 48-bit acquisition time goes in, four bytes of seconds then two bytes of fraction.
// RULE5 - the data field header carries service version 010, checksum flag 0, spare 0000 and a zero pad byte after the subtype.
// RULE6 - the spectrometer report service type is 00000101.
// RULE7 - the spectrometer report service subtype is 00000011.
// RULE8 - the spectrometer report source data is the event identifier 43009, hex a801.
// RULE9 - the spectrometer report is raised when the busy line is still high when the scan should have ended.
// RULE10 - an acceptance-success report leaves no later than 4 seconds after a telecommand is received.
// RULE11 - the acceptance-success report uses category 1, type 1, subtype 1 and 32 bits of source data.
// RULE12 - acceptance-success source data is the command packet identifier word then its sequence control word.
// RULE13 - busy is checked once a programmable scan timer expires after scan start, with at most one report per scan.
`ifndef ERPB_REGS_SVH
`define ERPB_REGS_SVH
`define ERPB_VERSION        3'h0
`define ERPB_TYPE           1'h0
`define ERPB_DFH_FLAG       1'h1
`define ERPB_APID           7'h47
`define ERPB_CAT_EVENT      4'h7
`define ERPB_CAT_ACCEPT     4'h1
`define ERPB_SEG_FLAGS      2'h3
`define ERPB_LEN_OFFSET     16'h0009
`define ERPB_SPEC_SRC_BYTES 16'h0002
`define ERPB_ACC_SRC_BYTES  16'h0004
`define ERPB_SVC_VERSION    3'h2
`define ERPB_CKSUM_FLAG     1'h0
`define ERPB_SPARE          4'h0
`define ERPB_PAD            8'h00
`define ERPB_TYPE_EVENT     8'h05
`define ERPB_SUB_GROUND     8'h03
`define ERPB_TYPE_TCVER     8'h01
`define ERPB_SUB_ACCEPT     8'h01
`define ERPB_EVENT_ID       16'ha801
`define ERPB_CLK_HZ         50000000
`define ERPB_ACCEPT_SEC     4
`define ERPB_ACCEPT_CYC     (`ERPB_CLK_HZ * `ERPB_ACCEPT_SEC)
`endif

// ===== hw/erpb_pkg.sv
package erpb_pkg;
  // primary header of a packet
  typedef struct packed {
    logic [2:0]  version;
    logic        pkt_type;
    logic        dfh_flag;
    logic [6:0]  apid;
    logic [3:0]  category;
    logic [1:0]  segmentation_flags_field;
    logic [13:0] seq_count;
    logic [15:0] packet_length_field;
  } erpb_primary_type;
  // data field header including time
  typedef struct packed {
    logic [47:0] acquisition_time_field;
    logic [2:0]  service_version_field;
    logic        checksum_flag_field;
    logic [3:0]  spare_bits_field;
    logic [7:0]  service_type_field;
    logic [7:0]  service_subtype_field;
    logic [7:0]  header_pad_field;
  } erpb_dfh_type;
  // full packet, source data left aligned in 32 bits
  typedef struct packed {
    erpb_primary_type primary;
    erpb_dfh_type     dfh;
    logic [31:0]      source_data;
    logic [2:0]       src_bytes;
  } erpb_packet_type;
  typedef enum logic [1:0] {
    ERPB_IDLE  = 2'b00,
    ERPB_TIMED = 2'b01,
    ERPB_DONE  = 2'b10
  } erpb_scan_type;
endpackage

// ===== hw/erpb_builder.sv
`timescale 1ns/1ns
`include "erpb_regs.svh"
module erpb_builder #(
  parameter int unsigned ACCEPT_CYCLES = `ERPB_ACCEPT_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   scan_start,
  input  wire logic                   spec_busy,
  input  wire logic [31:0]            scan_cycles,
  input  wire logic [47:0]            time_now,
  input  wire logic                   tc_accepted,
  input  wire logic [15:0]            tc_packet_id,
  input  wire logic [15:0]            tc_seq_control,
  input  wire logic                   pkt_ready,
  output logic                        pkt_valid,
  output erpb_pkg::erpb_packet_type   pkt,
  output logic                        accept_pending,
  output logic                        accept_late
);
  logic                      busy_meta;
  logic                      busy_sync;
  erpb_pkg::erpb_scan_type   scan_state;
  logic [31:0]               scan_timer;
  logic                      spec_req;
  logic [47:0]               spec_time;
  logic [47:0]               acc_time;
  logic [15:0]               acc_pid;
  logic [15:0]               acc_seq;
  logic [31:0]               acc_timer;
  logic [13:0]               seq_event;
  logic [13:0]               seq_accept;
  logic                      send_spec;
  logic                      send_acc;
  logic                      fire;
  logic                      sel_spec;

  // assemble one packet from category, type, subtype, count and data
  function automatic erpb_pkg::erpb_packet_type build(
    input logic [3:0]  cat,
    input logic [7:0]  styp,
    input logic [7:0]  ssub,
    input logic [13:0] cnt,
    input logic [47:0] tstamp,
    input logic [31:0] data,
    input logic [15:0] nbytes
  );
    erpb_pkg::erpb_packet_type p;
    p.primary.version  = `ERPB_VERSION; // RULE1
    p.primary.pkt_type = `ERPB_TYPE;
    p.primary.dfh_flag = `ERPB_DFH_FLAG;
    p.primary.apid     = `ERPB_APID;
    p.primary.category = cat;
    p.primary.segmentation_flags_field = `ERPB_SEG_FLAGS;
    p.primary.seq_count = cnt;
    p.primary.packet_length_field = nbytes + `ERPB_LEN_OFFSET; // RULE3
    p.dfh.acquisition_time_field = tstamp; // RULE4
    p.dfh.service_version_field  = `ERPB_SVC_VERSION; // RULE5
    p.dfh.checksum_flag_field    = `ERPB_CKSUM_FLAG;
    p.dfh.spare_bits_field       = `ERPB_SPARE;
    p.dfh.service_type_field     = styp;
    p.dfh.service_subtype_field  = ssub;
    p.dfh.header_pad_field       = `ERPB_PAD;
    p.source_data = data;
    p.src_bytes   = nbytes[2:0];
    return p;
  endfunction

  // busy line comes from another chip: two flip-flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end else begin
      busy_meta <= spec_busy;
      busy_sync <= busy_meta;
    end
  end

  // scan timer: one check per scan when the timer runs out
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_state <= erpb_pkg::ERPB_IDLE;
      scan_timer <= 32'h0;
    end else begin
      case (scan_state)
        erpb_pkg::ERPB_IDLE, erpb_pkg::ERPB_DONE: begin
          if (scan_start) begin
            scan_state <= erpb_pkg::ERPB_TIMED; // RULE13
            scan_timer <= scan_cycles;
          end
        end
        erpb_pkg::ERPB_TIMED: begin
          if (scan_timer == 32'h0) begin
            scan_state <= erpb_pkg::ERPB_DONE; // RULE13
          end else begin
            scan_timer <= scan_timer - 32'h1;
          end
        end
        default: scan_state <= erpb_pkg::ERPB_IDLE;
      endcase
    end
  end

  // latch a spectrometer report when busy is still high at expiry
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spec_req <= 1'b0;
    end else if (scan_state == erpb_pkg::ERPB_TIMED &&
                 scan_timer == 32'h0 && busy_sync) begin
      spec_req <= 1'b1; // RULE9
    end else if (send_spec) begin
      spec_req <= 1'b0;
    end
  end

  // time stamp taken when a scan is accepted, not while one is timed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spec_time <= 48'h0;
    end else if (scan_start && scan_state != erpb_pkg::ERPB_TIMED) begin
      spec_time <= time_now; // RULE4
    end
  end

  // catch an accepted telecommand and watch its deadline
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      accept_pending <= 1'b0;
      accept_late    <= 1'b0;
      acc_time       <= 48'h0;
      acc_pid        <= 16'h0;
      acc_seq        <= 16'h0;
      acc_timer      <= 32'h0;
    end else if (tc_accepted && !accept_pending) begin
      accept_pending <= 1'b1;
      acc_time       <= time_now;
      acc_pid        <= tc_packet_id; // RULE12
      acc_seq        <= tc_seq_control;
      acc_timer      <= 32'h0;
    end else if (send_acc) begin
      accept_pending <= 1'b0;
    end else if (accept_pending) begin
      acc_timer <= acc_timer + 32'h1;
      if (acc_timer >= ACCEPT_CYCLES - 1)
        accept_late <= 1'b1; // RULE10
    end
  end

  // arbitration: pending command acceptance first, it carries a deadline
  assign fire      = !pkt_valid || pkt_ready;
  assign send_acc  = fire && accept_pending; // RULE10
  assign send_spec = fire && spec_req && !accept_pending;

  // per pair sequence counters
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seq_event  <= 14'h0;
      seq_accept <= 14'h0;
    end else begin
      if (send_spec)
        seq_event <= seq_event + 14'h1; // RULE2
      if (send_acc)
        seq_accept <= seq_accept + 14'h1; // RULE2
    end
  end

  // output packet register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pkt_valid <= 1'b0;
      pkt       <= '0;
      sel_spec  <= 1'b0;
    end else if (send_acc) begin
      pkt_valid <= 1'b1;
      sel_spec  <= 1'b0;
      pkt <= build(`ERPB_CAT_ACCEPT, `ERPB_TYPE_TCVER, // RULE11
                   `ERPB_SUB_ACCEPT, seq_accept, acc_time,
                   {acc_pid, acc_seq}, `ERPB_ACC_SRC_BYTES); // RULE12
    end else if (send_spec) begin
      pkt_valid <= 1'b1;
      sel_spec  <= 1'b1;
      pkt <= build(`ERPB_CAT_EVENT, `ERPB_TYPE_EVENT, // RULE6
                   `ERPB_SUB_GROUND, seq_event, spec_time, // RULE7
                   {`ERPB_EVENT_ID, 16'h0000}, // RULE8
                   `ERPB_SPEC_SRC_BYTES);
    end else if (pkt_ready) begin
      pkt_valid <= 1'b0;
    end
  end
endmodule

// ===== testbench/erpb_chk.sv
`timescale 1ns/1ns
module erpb_chk (
  input wire logic                      sys_clk,
  input wire logic                      nrst,
  input wire logic                      tc_accepted,
  input wire logic                      pkt_ready,
  input wire logic                      pkt_valid,
  input wire erpb_pkg::erpb_packet_type pkt,
  input wire logic                      accept_pending
);
  logic [13:0] n_ev;
  logic [13:0] n_acc;
  logic        ev;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // packet is a spectrometer event report
  assign ev = pkt.primary.category == 4'h7;
  // packets taken so far, one count per category
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      n_ev  <= 14'h0;
      n_acc <= 14'h0;
    end else if (pkt_valid && pkt_ready) begin
      if (ev) n_ev <= n_ev + 14'h1;
      else n_acc <= n_acc + 14'h1;
    end
  end
  property p_hold;
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt);
  endproperty
  a_hold: assert property (p_hold) else $error("packet moved early");
  property p_seq;
    pkt_valid |-> pkt.primary.seq_count == (ev ? n_ev : n_acc);
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequence count wrong");
  property p_len;
    pkt_valid |-> pkt.primary.packet_length_field == 16'h9 + pkt.src_bytes;
  endproperty
  a_len: assert property (p_len)
    else $error("length field wrong");
  property p_dfh;
    pkt_valid |-> pkt.dfh[31:0] == ({3'h2, 1'h0, 4'h0, 24'h0} |
      {8'h0, pkt.dfh.service_type_field, pkt.dfh.service_subtype_field, 8'h0});
  endproperty
  a_dfh: assert property (p_dfh)
    else $error("data field header constants wrong");
  property p_ev_hdr;
    pkt_valid && ev |-> pkt.primary[47:30] == {5'b00001, 7'h47, 4'h7, 2'h3};
  endproperty
  a_ev_hdr: assert property (p_ev_hdr)
    else $error("event primary header wrong");
  property p_ev_svc;
    pkt_valid && ev |-> pkt.dfh[23:8] == 16'h0503;
  endproperty
  a_ev_svc: assert property (p_ev_svc)
    else $error("event service type wrong");
  property p_ev_src;
    pkt_valid && ev |-> pkt.source_data == 32'ha8010000 && pkt.src_bytes == 2;
  endproperty
  a_ev_src: assert property (p_ev_src)
    else $error("event identifier wrong");
  property p_acc;
    tc_accepted && !accept_pending && !pkt_valid |=>
      accept_pending ##[1:8] (pkt_valid && !ev && pkt.dfh[23:8] == 16'h0101);
  endproperty
  a_acc: assert property (p_acc)
    else $error("acceptance report missing");
endmodule
bind erpb_builder erpb_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .tc_accepted(tc_accepted), .pkt_ready(pkt_ready), .pkt_valid(pkt_valid),
  .pkt(pkt), .accept_pending(accept_pending));

// ===== testbench/erpb_sink.sv
`timescale 1ns/1ns
module erpb_sink (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic slow,
  output logic     pkt_ready
);
  // data handling side: ready always, or every other cycle when slow
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) pkt_ready <= 1'b0;
    else pkt_ready <= !slow || !pkt_ready;
  end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 0, nrst = 0, scan_start = 0, spec_busy = 0, slow = 0;
  logic tc_accepted = 0, pkt_ready, pkt_valid, accept_pending, accept_late;
  logic [31:0] scan_cycles = 32'h14;
  logic [47:0] time_now = 48'h0;
  logic [15:0] tc_packet_id = 16'h0, tc_seq_control = 16'h0;
  erpb_pkg::erpb_packet_type pkt, p;
  int n_mismatch = 0, total_checks = 0;
  bit got;
  erpb_builder #(.ACCEPT_CYCLES(50)) dut (
    .sys_clk       (sys_clk),
    .nrst          (nrst),
    .scan_start    (scan_start),
    .spec_busy     (spec_busy),
    .scan_cycles   (scan_cycles),
    .time_now      (time_now),
    .tc_accepted   (tc_accepted),
    .tc_packet_id  (tc_packet_id),
    .tc_seq_control(tc_seq_control),
    .pkt_ready     (pkt_ready),
    .pkt_valid     (pkt_valid),
    .pkt           (pkt),
    .accept_pending(accept_pending),
    .accept_late   (accept_late)
  );
  erpb_sink sink (.sys_clk(sys_clk), .nrst(nrst), .slow(slow),
    .pkt_ready(pkt_ready));
  always #10 sys_clk = ~sys_clk;
  task chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // wait a bounded time for one packet to be taken
  task take;
    got = 0;
    for (int i = 0; i < 60 && !got; i++) begin
      @(posedge sys_clk);
      if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
        p = pkt;
        got = 1;
      end
    end
  endtask
  task t_accept(input logic [15:0] id, input logic [15:0] sq, input int n);
    @(posedge sys_clk);
    tc_accepted <= 1; tc_packet_id <= id; tc_seq_control <= sq;
    time_now <= {16'h0, id, sq};
    @(posedge sys_clk);
    tc_accepted <= 0; time_now <= 48'h0;
    take();
    chk("acc seen", 1, got);
    chk("acc src", {id, sq}, p.source_data);
    chk("acc svc", 23'h08080c, {p.primary.category, p.dfh[23:8], p.src_bytes});
    chk("acc seq", n, p.primary.seq_count);
    chk("acc time", {16'h0, id, sq}, p.dfh.acquisition_time_field);
    chk("acc len", 16'hd, p.primary.packet_length_field);
    chk("acc pending", 0, accept_pending);
    chk("acc late", 0, accept_late);
  endtask
  task t_scan(input logic busy, input int n);
    @(posedge sys_clk);
    scan_start <= 1; spec_busy <= busy; time_now <= 48'h12345678abcd;
    @(posedge sys_clk);
    scan_start <= 0; time_now <= 48'h0;
    take();
    chk("scan report", busy, got);
    if (got) begin
      chk("ev hdr", 50'h031df40050300, {p.primary[47:30], p.dfh[31:0]});
      chk("ev len", 16'hb, p.primary.packet_length_field);
      chk("ev id", 32'ha8010000, p.source_data);
      chk("ev time", 48'h12345678abcd, p.dfh.acquisition_time_field);
      chk("ev seq", n, p.primary.seq_count);
      take();
      chk("second report", 0, got);
    end
    spec_busy <= 0;
  endtask
  task conclude;
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1;
    t_accept(16'h1234, 16'hc001, 0);
    t_accept(16'hfffe, 16'h0002, 1);
    t_scan(1, 0);
    t_scan(0, 1);
    slow <= 1;
    t_scan(1, 1);
    t_accept(16'h8001, 16'h7fff, 2);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule
